// ---- logic/aux_alert_threshold_bank.sv ----
// Overview of operation
// RULE1: Ratiometric result above over set threshold raises the over alert.
// RULE2: Ratiometric result at or below over clear threshold drops the over alert.
// RULE3: Ratiometric result at or above under clear threshold drops the under alert.
// RULE4: Ratiometric result below under set threshold raises the under alert.
// RULE5: Absolute result at or below absolute over clear threshold drops over alert.
// RULE6: Absolute result above absolute over set threshold raises the over alert.
// RULE7: Reference select bit 0 uses ratiometric thresholds, 1 uses absolute ones.
// RULE8: Over set threshold of all ones never raises the over alert.
// RULE9: Under set threshold of zero never raises the under alert.
// RULE10: Software keeps ratiometric under clear at or above under set.
// RULE11: Software keeps absolute over clear at or below absolute over set.
// RULE12: Between clear and set thresholds an alert keeps its previous state.
// RULE13: Threshold bits 1:0 read zero; compare against result bits 15:2.
module aux_alert_threshold_bank #(
   parameter int unsigned NUM_CHANNELS = 6,
   parameter int unsigned ADDR_W       = 8
) (
   input  wire logic                    clk,
   input  wire logic                    nrst,
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [ADDR_W-1:0]       paddr,
   input  wire logic [31:0]             pwdata,
   input  wire logic [3:0]              pstrb,
   output logic      [31:0]             prdata,
   output logic                         pready,
   output logic                         pslverr,
   input  wire aux_alert_pkg::meas_t    meas,
   output logic      [NUM_CHANNELS-1:0] aux_over_alert,
   output logic      [NUM_CHANNELS-1:0] aux_under_alert
);

   // Threshold storage, 14-bit fields only
   logic [13:0]             thr_q [aux_alert_pkg::THR_COUNT];
   logic [NUM_CHANNELS-1:0] ref_select_q;
   logic [18:0]             last_result_q;
   logic [31:0]             prdata_d;
   logic                    pslverr_d;

   // Decode
   wire  [5:0]  reg_idx     = paddr[7:2];
   wire         aligned     = paddr[1:0] == 2'b00;
   wire         setup_phase = psel & ~penable;
   wire         write_edge  = psel & penable & pready & pwrite;
   wire  [5:0]  thr_offset  = reg_idx - aux_alert_pkg::THR_BASE_IDX;
   wire         hit_thr     = aligned & (reg_idx >= aux_alert_pkg::THR_BASE_IDX)
                              & (thr_offset < 6'(aux_alert_pkg::THR_COUNT));
   wire  [2:0]  thr_slot    = thr_offset[2:0];
   wire         hit_ref     = aligned & (reg_idx == aux_alert_pkg::IDX_REFERENCE_SELECT);
   wire         hit_status  = aligned & (reg_idx == aux_alert_pkg::IDX_ALERT_STATUS);
   wire         hit_last    = aligned & (reg_idx == aux_alert_pkg::IDX_LAST_RESULT);
   wire         mapped      = hit_thr | hit_ref | hit_status | hit_last;

   // Named views of the threshold fields
   wire  [13:0] ratio_over_clear_value  = thr_q[aux_alert_pkg::SLOT_RATIO_OVER_CLEAR];
   wire  [13:0] ratio_over_set_value    = thr_q[aux_alert_pkg::SLOT_RATIO_OVER_SET];
   wire  [13:0] ratio_under_clear_value = thr_q[aux_alert_pkg::SLOT_RATIO_UNDER_CLEAR];
   wire  [13:0] ratio_under_set_value   = thr_q[aux_alert_pkg::SLOT_RATIO_UNDER_SET];
   wire  [13:0] abs_over_clear_value    = thr_q[aux_alert_pkg::SLOT_ABS_OVER_CLEAR];
   wire  [13:0] abs_over_set_value      = thr_q[aux_alert_pkg::SLOT_ABS_OVER_SET];

   // Threshold write merge per byte lane; bits 1:0 are dropped
   wire  [13:0] thr_old = thr_q[thr_slot];
   wire  [13:0] thr_wr  = {pstrb[1] ? pwdata[15:8] : thr_old[13:6],
                           pstrb[0] ? pwdata[7:2]  : thr_old[5:0]}; // RULE13

   wire  [NUM_CHANNELS-1:0] ref_wr;

   aux_alert_pkg::thr_set_t ratio_thr;
   aux_alert_pkg::thr_set_t abs_thr;

   assign ratio_thr.under_en    = 1'b1;
   assign ratio_thr.over_set    = ratio_over_set_value;
   assign ratio_thr.over_clear  = ratio_over_clear_value;
   assign ratio_thr.under_set   = ratio_under_set_value;
   assign ratio_thr.under_clear = ratio_under_clear_value;

   // No absolute under thresholds here, so absolute channels hold the under alert
   assign abs_thr.under_en    = 1'b0;
   assign abs_thr.over_set    = abs_over_set_value;
   assign abs_thr.over_clear  = abs_over_clear_value;
   assign abs_thr.under_set   = aux_alert_pkg::THR_ZERO;
   assign abs_thr.under_clear = aux_alert_pkg::THR_ZERO;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_CHANNELS; gi++) begin : g_ref
         if (gi < 8) begin : g_lo
            assign ref_wr[gi] = pstrb[0] ? pwdata[gi] : ref_select_q[gi];
         end else begin : g_hi
            assign ref_wr[gi] = pstrb[1] ? pwdata[gi] : ref_select_q[gi];
         end
      end
   endgenerate

   // Read mux
   always_comb begin
      prdata_d = 32'h0000_0000;
      if (hit_thr) begin
         prdata_d[aux_alert_pkg::THR_MSB:aux_alert_pkg::THR_LSB] = thr_old; // RULE13
      end else if (hit_ref) begin
         prdata_d[NUM_CHANNELS-1:0] = ref_select_q;
      end else if (hit_status) begin
         prdata_d[NUM_CHANNELS-1:0] = aux_over_alert;
         prdata_d[aux_alert_pkg::STAT_UNDER_LSB +: NUM_CHANNELS] = aux_under_alert;
      end else if (hit_last) begin
         prdata_d[18:0] = last_result_q;
      end
   end

   // Writes to the read-only status and last-result words are errors as well
   assign pslverr_d = ~mapped | (pwrite & (hit_status | hit_last));

   // APB slave: answer prepared in the setup cycle, ready in the first access cycle
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= setup_phase;
         pslverr <= setup_phase & pslverr_d;
         prdata  <= (setup_phase & ~pwrite) ? prdata_d : 32'h0000_0000;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < aux_alert_pkg::THR_COUNT; i++) begin
            thr_q[i] <= aux_alert_pkg::THR_RESET[i];
         end
      end else if (write_edge & hit_thr) begin
         thr_q[thr_slot] <= thr_wr;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ref_select_q <= NUM_CHANNELS'(aux_alert_pkg::REF_SELECT_RESET);
      end else if (write_edge & hit_ref) begin
         ref_select_q <= ref_wr; // RULE7
      end
   end

   // Last accepted measurement, channel in bits 18:16, result in bits 15:0
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         last_result_q <= 19'h0_0000;
      end else if (meas.valid && (32'(meas.channel) < NUM_CHANNELS)) begin
         last_result_q <= {meas.channel, meas.data};
      end
   end

   // One comparator per auxiliary channel
   generate
      for (gi = 0; gi < NUM_CHANNELS; gi++) begin : g_chan
         wire sample = meas.valid & (32'(meas.channel) == gi);
         aux_alert_channel u_chan (
            .clk         (clk),
            .nrst        (nrst),
            .sample      (sample),
            .ref_select  (ref_select_q[gi]), // RULE7
            .result      (meas.data),
            .ratio_thr   (ratio_thr),
            .abs_thr     (abs_thr),
            .over_alert  (aux_over_alert[gi]),
            .under_alert (aux_under_alert[gi])
         );
      end
   endgenerate

endmodule

// ---- logic/aux_alert_pkg.sv ----
package aux_alert_pkg;

   // Register indices; the byte address of each register is four times its index
   localparam logic [5:0] IDX_RATIO_OVER_CLEAR_THRESHOLD = 6'h30;
   localparam logic [5:0] IDX_RATIO_OVER_SET_THRESHOLD   = 6'h31;
   localparam logic [5:0] IDX_RATIO_UNDER_CLEAR_THRESHOLD = 6'h32;
   localparam logic [5:0] IDX_RATIO_UNDER_SET_THRESHOLD  = 6'h33;
   localparam logic [5:0] IDX_ABS_OVER_CLEAR_THRESHOLD   = 6'h34;
   localparam logic [5:0] IDX_ABS_OVER_SET_THRESHOLD     = 6'h35;
   localparam logic [5:0] IDX_REFERENCE_SELECT           = 6'h3C;
   localparam logic [5:0] IDX_ALERT_STATUS               = 6'h3D;
   localparam logic [5:0] IDX_LAST_RESULT                = 6'h3E;

   // Threshold slots in the register array, counted from the first index
   localparam logic [5:0] THR_BASE_IDX = IDX_RATIO_OVER_CLEAR_THRESHOLD;
   localparam int unsigned THR_COUNT   = 6;
   localparam logic [2:0] SLOT_RATIO_OVER_CLEAR  = 3'h0;
   localparam logic [2:0] SLOT_RATIO_OVER_SET    = 3'h1;
   localparam logic [2:0] SLOT_RATIO_UNDER_CLEAR = 3'h2;
   localparam logic [2:0] SLOT_RATIO_UNDER_SET   = 3'h3;
   localparam logic [2:0] SLOT_ABS_OVER_CLEAR    = 3'h4;
   localparam logic [2:0] SLOT_ABS_OVER_SET      = 3'h5;

   // Threshold field: 14 bits held in bits 15:2, bits 1:0 read as zero
   localparam int unsigned THR_W   = 14;
   localparam int unsigned THR_LSB = 2;
   localparam int unsigned THR_MSB = 15;
   localparam logic [13:0] THR_ALL_ONES = 14'h3FFF;
   localparam logic [13:0] THR_ZERO     = 14'h0000;
   localparam logic [13:0] THR_RESET [THR_COUNT] = '{
      THR_ALL_ONES, THR_ALL_ONES, THR_ZERO, THR_ZERO, THR_ALL_ONES, THR_ALL_ONES};

   // Own register layouts
   localparam int unsigned STAT_UNDER_LSB  = 8;
   localparam int unsigned LAST_CHAN_LSB   = 16;
   localparam int unsigned RESULT_W        = 16;
   localparam int unsigned CHAN_W          = 3;
   localparam logic [5:0]  REF_SELECT_RESET = 6'h00;

   typedef struct packed {
      logic        under_en;
      logic [13:0] over_set;
      logic [13:0] over_clear;
      logic [13:0] under_set;
      logic [13:0] under_clear;
   } thr_set_t;

   typedef struct packed {
      logic        valid;
      logic [2:0]  channel;
      logic [15:0] data;
   } meas_t;

endpackage

// ---- logic/aux_alert_channel.sv ----
module aux_alert_channel (
   input  wire logic                   clk,
   input  wire logic                   nrst,
   input  wire logic                   sample,
   input  wire logic                   ref_select,
   input  wire logic [15:0]            result,
   input  wire aux_alert_pkg::thr_set_t ratio_thr,
   input  wire aux_alert_pkg::thr_set_t abs_thr,
   output logic                        over_alert,
   output logic                        under_alert
);

   aux_alert_pkg::thr_set_t thr;
   logic [13:0]             level;
   logic                    over_set_hit;
   logic                    over_clear_hit;
   logic                    under_set_hit;
   logic                    under_clear_hit;
   logic                    over_d;
   logic                    under_d;

   assign thr   = ref_select ? abs_thr : ratio_thr; // RULE7
   assign level = result[aux_alert_pkg::THR_MSB:aux_alert_pkg::THR_LSB]; // RULE13

   // All-ones over set and zero under set can never be crossed
   assign over_set_hit    = level > thr.over_set; // RULE1 RULE6 RULE8
   assign over_clear_hit  = level <= thr.over_clear; // RULE2 RULE5
   assign under_set_hit   = thr.under_en & (level < thr.under_set); // RULE4 RULE9
   assign under_clear_hit = thr.under_en & (level >= thr.under_clear); // RULE3

   // Set wins if software programmed the clear level past the set level
   assign over_d  = over_set_hit ? 1'b1 : (over_clear_hit ? 1'b0 : over_alert); // RULE12
   assign under_d = under_set_hit ? 1'b1 : (under_clear_hit ? 1'b0 : under_alert); // RULE12

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         over_alert  <= 1'b0;
         under_alert <= 1'b0;
      end else if (sample) begin
         over_alert  <= over_d;
         under_alert <= under_d;
      end
   end

endmodule

// ---- bench/aux_alert_threshold_bank_props.sv ----
module aux_alert_threshold_bank_props #(
   parameter int unsigned NUM_CHANNELS = 6,
   parameter int unsigned ADDR_W       = 8
) (
   input wire logic                    clk,
   input wire logic                    nrst,
   input wire logic                    psel,
   input wire logic                    penable,
   input wire logic                    pwrite,
   input wire logic [ADDR_W-1:0]       paddr,
   input wire logic [31:0]             prdata,
   input wire logic                    pready,
   input wire logic                    pslverr,
   input wire aux_alert_pkg::meas_t    meas,
   input wire logic [NUM_CHANNELS-1:0] aux_over_alert,
   input wire logic [NUM_CHANNELS-1:0] aux_under_alert
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   wire logic [5:0] idx = paddr[7:2];
   wire logic       map_ok = paddr[1:0] == 2'b00 && (idx inside {[6'h30:6'h35], 6'h3C, 6'h3D, 6'h3E});
   wire logic       ro_wr = pwrite && (idx inside {6'h3D, 6'h3E});
   wire logic       setup = psel && !penable;
   wire logic       hit = meas.valid && meas.channel < NUM_CHANNELS;
   wire logic [NUM_CHANNELS-1:0] one = NUM_CHANNELS'(1);

   ready_after_setup_a: assert property (setup |=> pready && psel && penable) else $error("no ready after setup");
   ready_in_access_a: assert property (pready |-> psel && penable) else $error("ready outside access");
   err_with_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
   rdata_idle_zero_a: assert property (!pready |-> prdata == 32'h0) else $error("read data not zero");
   bad_addr_err_a: assert property (setup && (!map_ok || ro_wr) |=> pslverr) else $error("bad access not refused");
   good_addr_ok_a: assert property (setup && map_ok && !ro_wr |=> !pslverr) else $error("good access refused");
   alert_hold_a: assert property (!hit |=> $stable(aux_over_alert) && $stable(aux_under_alert))
      else $error("alert moved without sample");
   one_chan_a: assert property (meas.valid |=> (((aux_over_alert ^ $past(aux_over_alert))
      | (aux_under_alert ^ $past(aux_under_alert))) & ~(one << $past(meas.channel))) == '0)
      else $error("alert of other channel moved");

   cover property (meas.valid ##1 $rose(aux_over_alert[0]));
   cover property (meas.valid ##1 $rose(aux_under_alert[0]));
   cover property (pslverr);
endmodule

bind aux_alert_threshold_bank aux_alert_threshold_bank_props #(.NUM_CHANNELS(NUM_CHANNELS), .ADDR_W(ADDR_W)) i_props (
   .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .meas(meas), .aux_over_alert(aux_over_alert),
   .aux_under_alert(aux_under_alert));

// ---- bench/aux_alert_threshold_bank_tb.sv ----
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module aux_alert_threshold_bank_tb;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct {logic [2:0] ch; logic [13:0] lvl; logic ov; logic uv;} step_t;
   logic                clk, nrst, psel, penable, pwrite, pready, pslverr;
   logic [7:0]          paddr;
   logic [31:0]         pwdata, prdata, rd;
   logic [3:0]          pstrb;
   logic [5:0]          aux_over_alert, aux_under_alert;
   logic                err;
   aux_alert_pkg::meas_t meas;
   int                  failures = 0;
   int                  n_tests = 0;
   // Thresholds are written as value << 2; ch1 switched to absolute
   logic [5:0]  widx [7] = '{6'h31, 6'h30, 6'h33, 6'h32, 6'h35, 6'h34, 6'h3C};
   logic [31:0] wval [7] = '{32'h4000, 32'h2000, 32'h1000, 32'h1800, 32'h8000, 32'h6000, 32'h2};
   step_t steps [14] = '{
      '{0, 14'h1000, 0, 0}, '{0, 14'h1001, 1, 0},
      '{0, 14'h0801, 1, 0}, '{0, 14'h0800, 0, 0},
      '{0, 14'h0400, 0, 0}, '{0, 14'h03FF, 0, 1},
      '{0, 14'h05FF, 0, 1}, '{0, 14'h0600, 0, 0},
      '{1, 14'h1800, 0, 0}, '{1, 14'h2001, 1, 0},
      '{1, 14'h1801, 1, 0}, '{1, 14'h1800, 0, 0},
      '{0, 14'h1800, 1, 0}, '{2, 14'h0000, 0, 1}};

   aux_alert_threshold_bank i_dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .meas(meas), .aux_over_alert(aux_over_alert), .aux_under_alert(aux_under_alert));

   always #2 clk = ~clk;

   task automatic apb(input logic wr, input logic [5:0] idx, input logic [1:0] lo, input logic [31:0] wd);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {idx, lo};
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rreg(input logic [5:0] idx, input logic [1:0] lo, input logic [31:0] exp, input logic eerr);
      apb(1'b0, idx, lo, 32'h0);
      `CHK(rd, exp)
      `CHK(err, eerr)
   endtask

   task automatic step(input step_t s);
      @(posedge clk);
      meas <= '{1'b1, s.ch, {s.lvl, 2'b11}};
      @(posedge clk);
      meas.valid <= 1'b0;
      @(posedge clk);
      `CHK({aux_over_alert[s.ch], aux_under_alert[s.ch]}, {s.ov, s.uv})
   endtask

   task automatic end_sim();
      if (failures == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      repeat (3000) @(posedge clk);
      failures++;
      end_sim();
   end

   initial begin
      clk = 0;
      nrst = 0;
      psel = 0;
      penable = 0;
      pwrite = 0;
      paddr = '0;
      pwdata = '0;
      pstrb = 4'hF;
      meas = '0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      for (int i = 0; i < 6; i++)
         rreg(6'h30 + 6'(i), 2'b00, (i == 2 || i == 3) ? 32'h0 : 32'hFFFC, 1'b0);
      step('{0, 14'h3FFF, 0, 0});
      step('{0, 14'h0000, 0, 0});
      apb(1'b1, 6'h31, 2'b00, 32'hFFFF);
      rreg(6'h31, 2'b00, 32'hFFFC, 1'b0);
      for (int i = 0; i < 7; i++)
         apb(1'b1, widx[i], 2'b00, wval[i]);
      rreg(6'h3C, 2'b00, 32'h2, 1'b0);
      foreach (steps[i])
         step(steps[i]);
      rreg(6'h00, 2'b00, 32'h0, 1'b1);
      rreg(6'h31, 2'b01, 32'h0, 1'b1);
      // Channel 6 does not exist: no alert and no last result may move
      @(posedge clk);
      meas <= '{1'b1, 3'h6, 16'hFFFF};
      @(posedge clk);
      meas.valid <= 1'b0;
      apb(1'b1, 6'h3D, 2'b00, 32'hFFFF);
      `CHK(err, 1'b1)
      rreg(6'h3D, 2'b00, 32'h0000_0401, 1'b0);
      rreg(6'h3E, 2'b00, 32'h0002_0003, 1'b0);
      // Lane 0 only: field bits 5:0 change, bits 13:6 keep their value
      pstrb <= 4'h1;
      apb(1'b1, 6'h30, 2'b00, 32'hFFFF);
      pstrb <= 4'hF;
      rreg(6'h30, 2'b00, 32'h20FC, 1'b0);
      // Reset in mid-run restores the defaults
      @(posedge clk);
      nrst <= 1'b0;
      @(posedge clk);
      nrst <= 1'b1;
      rreg(6'h31, 2'b00, 32'hFFFC, 1'b0);
      rreg(6'h3C, 2'b00, 32'h0, 1'b0);
      end_sim();
   end
endmodule
